/* File: design/dac_ctrl_pkg.sv */
// Package of constants for the voltage converter register interface
// Overview of operation
// - Enable bit powers converter up or down
// - Clear bit low forces data registers zero
// - Range bit picks supply or reference span
// - Byte mode: low byte drives MSBs
// - Pin select bit routes output pin
// - Upper control bits have no effect
// - Twelve-bit output updates on low write
// - Code right-justified across low, high nibble
// - Data registers decode at fb and fc
// - Data registers reset to zero
// - Data registers ignore single-bit addressing
// - Converter disabled, output off after reset
package dac_ctrl_pkg;
	localparam logic [7:0] data_low_addr = 8'hfb;
	localparam logic [7:0] data_high_addr = 8'hfc;
	localparam logic [7:0] control_addr = 8'hfd;
	localparam logic [7:0] data_reset = 8'h00;
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [11:0] code_reset = 12'h000;
	localparam int enable_bit = 0;
	localparam int clear_n_bit = 1;
	localparam int range_bit = 2;
	localparam int byte_mode_bit = 3;
	localparam int pin_sel_bit = 4;
	localparam logic [7:0] control_used_mask = 8'h1f;
endpackage : dac_ctrl_pkg

/* File: design/dac_byte_reg.sv */
// One byte-wide register with synchronous clear, written on strobe
module dac_byte_reg
	import dac_ctrl_pkg::*;
#(
	parameter logic [7:0] reset_value = 8'h00
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Write port
	input wire logic wr_i,
	input wire logic clr_i,
	input wire logic [7:0] data_i,
	// Stored value
	output logic [7:0] value_o
);
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			value_o <= reset_value;
		end else if (clr_i) begin
			value_o <= data_reset;
		end else if (wr_i) begin
			value_o <= data_i;
		end
	end
endmodule // dac_byte_reg

/* File: design/dac_ctrl.sv */
// Register interface and code update logic of the voltage converter
module dac_ctrl
	import dac_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Special-function register bus
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_bit_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Analog side
	output logic [11:0] code_o,
	output logic power_up_o,
	output logic output_en_o,
	output logic range_avdd_o,
	output logic pin_alt_o,
	output logic pin_main_o
);
	logic [7:0] control;
	logic [7:0] data_low;
	logic [7:0] data_high;
	logic wr_low;
	logic wr_high;
	logic clear;
	logic [11:0] next_code;
	logic [7:0] next_rdata;

	// Byte writes only; bit accesses are ignored
	assign wr_low = sfr_wr_i && !sfr_bit_i && sfr_addr_i == data_low_addr;
	assign wr_high = sfr_wr_i && !sfr_bit_i && sfr_addr_i == data_high_addr;
	assign clear = !control[clear_n_bit];

	// Control register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			control <= control_reset;
		end else if (sfr_wr_i && !sfr_bit_i && sfr_addr_i == control_addr) begin
			control <= sfr_wdata_i;
		end
	end

	dac_byte_reg #(
		.reset_value(data_reset)
	) u_low (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.wr_i(wr_low),
		.clr_i(clear),
		.data_i(sfr_wdata_i),
		.value_o(data_low)
	);

	dac_byte_reg #(
		.reset_value(data_reset)
	) u_high (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.wr_i(wr_high),
		.clr_i(clear),
		.data_i(sfr_wdata_i),
		.value_o(data_high)
	);

	// Code formed from the byte being written to the low register
	always_comb begin
		if (control[byte_mode_bit]) begin
			next_code = {sfr_wdata_i, 4'h0};
		end else begin
			next_code = {data_high[3:0], sfr_wdata_i};
		end
	end

	// Output code updates on a low-byte write and is held at zero while the clear bit is low
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			code_o <= code_reset;
		end else if (clear) begin
			code_o <= code_reset;
		end else if (wr_low) begin
			code_o <= next_code;
		end
	end

	// Analog controls; upper control bits unused
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			power_up_o <= 1'b0;
			output_en_o <= 1'b0;
			range_avdd_o <= 1'b0;
			pin_alt_o <= 1'b0;
			pin_main_o <= 1'b0;
		end else begin
			power_up_o <= control[enable_bit];
			output_en_o <= control[enable_bit];
			range_avdd_o <= control[range_bit];
			pin_alt_o <= control[enable_bit] && control[pin_sel_bit];
			pin_main_o <= control[enable_bit] && !control[pin_sel_bit];
		end
	end

	// Read data
	always_comb begin
		next_rdata = 8'h00;
		if (sfr_addr_i == data_low_addr) begin
			next_rdata = data_low;
		end else if (sfr_addr_i == data_high_addr) begin
			next_rdata = data_high;
		end else if (sfr_addr_i == control_addr) begin
			next_rdata = control;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_rdata_o <= next_rdata;
		end
	end
endmodule // dac_ctrl

/* File: verif/dac_ctrl_monitor.sv */
// Port assertions of the converter register interface
module dac_ctrl_monitor (
	input wire logic clock_i, rstn_i, sfr_wr_i, sfr_bit_i,
	input wire logic [7:0] sfr_addr_i, sfr_wdata_i,
	input wire logic [11:0] code_o,
	input wire logic power_up_o, output_en_o, range_avdd_o,
	input wire logic pin_alt_o, pin_main_o
);
	logic [7:0] ctl;
	wire w = sfr_wr_i && !sfr_bit_i;
	always_ff @(posedge clock_i or negedge rstn_i)
		if (!rstn_i) ctl <= 8'h00;
		else if (w && sfr_addr_i == 8'hfd) ctl <= sfr_wdata_i;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence low_wr; w && sfr_addr_i == 8'hfb; endsequence
	sequence ctl_wr; w && sfr_addr_i == 8'hfd; endsequence
	a_low_update: assert property (low_wr ##0 ctl[1] && !ctl[3]
		|=> code_o[7:0] == $past(sfr_wdata_i)) else $error("low");
	a_byte_code: assert property (low_wr ##0 ctl[1] && ctl[3]
		|=> code_o == {$past(sfr_wdata_i), 4'h0}) else $error("byte");
	a_high_hold: assert property (w && sfr_addr_i == 8'hfc && ctl[1]
		|=> $stable(code_o)) else $error("high");
	a_clear_zero: assert property (!ctl[1]
		|=> ##1 code_o == 12'h000) else $error("clear");
	a_power_follow: assert property (ctl_wr
		|=> ##1 power_up_o == $past(sfr_wdata_i[0], 2)) else $error("pwr");
	a_range_follow: assert property (ctl_wr
		|=> ##1 range_avdd_o == $past(sfr_wdata_i[2], 2)) else $error("rng");
	a_out_off: assert property (!ctl[0]
		|=> !output_en_o && !pin_alt_o && !pin_main_o) else $error("off");
	a_pin_route: assert property (ctl[0]
		|=> pin_alt_o == $past(ctl[4]) && pin_main_o != $past(ctl[4]))
		else $error("pin");
endmodule // dac_ctrl_monitor
bind dac_ctrl dac_ctrl_monitor mon_u (
	.clock_i(clock_i),
	.rstn_i(rstn_i),
	.sfr_wr_i(sfr_wr_i),
	.sfr_bit_i(sfr_bit_i),
	.sfr_addr_i(sfr_addr_i),
	.sfr_wdata_i(sfr_wdata_i),
	.code_o(code_o),
	.power_up_o(power_up_o),
	.output_en_o(output_en_o),
	.range_avdd_o(range_avdd_o),
	.pin_alt_o(pin_alt_o),
	.pin_main_o(pin_main_o)
);

/* File: verif/tb_top.sv */
// Bench of the converter register interface
`define chk(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value at %0t got %0h want %0h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 0, rstn_i = 0, sfr_wr_i = 0, sfr_bit_i = 0;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
	logic [11:0] code_o;
	logic power_up_o, output_en_o, range_avdd_o, pin_alt_o, pin_main_o;
	int error_cnt = 0, checks = 0;
	wire [4:0] outs = {power_up_o, output_en_o, range_avdd_o, pin_alt_o,
		pin_main_o};
	dac_ctrl dut_u (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i),
		.sfr_bit_i(sfr_bit_i),
		.sfr_wdata_i(sfr_wdata_i),
		.sfr_rdata_o(sfr_rdata_o),
		.code_o(code_o),
		.power_up_o(power_up_o),
		.output_en_o(output_en_o),
		.range_avdd_o(range_avdd_o),
		.pin_alt_o(pin_alt_o),
		.pin_main_o(pin_main_o)
	);
	initial forever #12.5 clock_i = !clock_i;
	task wr(input logic [7:0] a, d, input logic b = 1'b0);
		@(posedge clock_i);
		{sfr_addr_i, sfr_wdata_i, sfr_bit_i, sfr_wr_i} <= {a, d, b, 1'b1};
		@(posedge clock_i);
		sfr_wr_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clock_i);
		sfr_addr_i <= a;
		@(posedge clock_i);
		#1 `chk(sfr_rdata_o, e)
	endtask
	task ctl(input logic [7:0] d, input logic [4:0] e);
		wr(8'hfd, d);
		@(posedge clock_i);
		#1 `chk(outs, e)
	endtask
	task after_reset;
		`chk({outs, code_o}, 17'h0)
		rd(8'hfb, 8'h00);
		rd(8'hfc, 8'h00);
		rd(8'hfd, 8'h00);
	endtask
	task cleared_writes;
		wr(8'hfb, 8'h77);
		`chk(code_o, 12'h000)
		ctl(8'he3, 5'b11001);
		rd(8'hfd, 8'he3);
	endtask
	task twelve_bit;
		wr(8'hfc, 8'h0a);
		`chk(code_o, 12'h000)
		wr(8'hfb, 8'h55);
		`chk(code_o, 12'ha55)
		wr(8'hfb, 8'h11, 1'b1);
		`chk(code_o, 12'ha55)
		rd(8'hfc, 8'h0a);
		rd(8'hfb, 8'h55);
	endtask
	task mid_reset;
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		#1 `chk({outs, code_o}, 17'h0)
		rd(8'hfb, 8'h00);
		rd(8'hfc, 8'h00);
	endtask
	task byte_mode;
		ctl(8'h1f, 5'b11110);
		wr(8'hfc, 8'h0c);
		wr(8'hfb, 8'h5a);
		`chk(code_o, 12'h5a0)
		ctl(8'h00, 5'b00000);
		@(posedge clock_i);
		#1 `chk(code_o, 12'h000)
		rd(8'hfb, 8'h00);
		rd(8'hfc, 8'h00);
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		#1;
		after_reset;
		cleared_writes;
		twelve_bit;
		mid_reset;
		byte_mode;
		report_and_stop;
	end
	initial begin
		#20us;
		error_cnt++;
		report_and_stop;
	end
endmodule // tb_top
